//--- core/timeout_guard.sv
// timeout guard: 32-bit down-counting watchdog with two response modes
//=================================================================
// Operation
// - 32-bit counter counts down; zero means timeout
// - counter advances on the bus clock
// - reset mode: timeout asserts system reset
// - interrupt mode: second uncleared timeout resets
// - reset pulse length set by software
// - period picked from sixteen ranges
`timescale 1ns/10ps
`default_nettype none
`include "timeout_guard_cfg.svh"
module timeout_guard
    import timeout_guard_pkg::*;
#(
    parameter int CNT_W = `TG_CNT_W
) (
    input  wire logic                     clk,        // bus clock
    input  wire logic                     rst,        // sync reset, high
    input  wire logic                     enable,     // guard enable level
    input  wire logic                     irq_mode,   // 1: interrupt first
    input  wire logic [`TG_RANGE_W-1:0]   range_sel,  // timeout range
    input  wire logic [`TG_PULSE_W-1:0]   pulse_sel,  // reset pulse length
    input  wire logic                     restart,    // reload pulse
    input  wire logic                     irq_clear,  // clear interrupt pulse
    output logic                          irq,        // timeout interrupt
    output logic                          sys_reset,  // system reset request
    output logic [CNT_W-1:0]              count       // current count
);
    //=================================================================
    // sizing
    // longest pulse is 2^(base+7) cycles, so the pulse counter needs base+8 bits
    localparam int                     PULSE_CNT_W = `TG_PULSE_BASE + (1 << `TG_PULSE_W);
    localparam int                     RANGE_TOP   = `TG_RANGE_BASE + (1 << `TG_RANGE_W) - 1;
    localparam logic [PULSE_CNT_W-1:0] PULSE_ONE   = PULSE_CNT_W'(1);
    // longest range must fit the counter; the preset math is only 64 bits wide
    if (CNT_W < RANGE_TOP || CNT_W > 64) begin : g_bad_cnt_w
        $error("counter width cannot hold every timeout range");
    end
    //=================================================================
    // preset and pulse length
    logic [CNT_W-1:0]       preset;
    logic [PULSE_CNT_W-1:0] pulse_len;
    logic [PULSE_CNT_W-1:0] pulse_cnt;
    guard_state_t           state;
    logic                   timeout;
    // ranges are 2^(16+n)-1, so each step doubles the period
    assign preset = CNT_W'((64'h1 << (`TG_RANGE_BASE + range_sel)) - 64'h1);
    // pulses are 2^(2+n) cycles; sized so the longest setting cannot wrap to zero
    assign pulse_len = PULSE_ONE << (`TG_PULSE_BASE + pulse_sel);
    assign timeout = (state == ST_RUN) && (count == '0);
    //=================================================================
    // counter
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (state != ST_RUN || restart) begin
            count <= preset;
        end else if (timeout) begin
            count <= preset;
        end else begin
            count <= count - 1'b1;
        end
    end
    //=================================================================
    // state and response
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            sys_reset <= 1'b0;
            pulse_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sys_reset <= 1'b0;
                    if (enable) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!enable) begin
                        state <= ST_IDLE;
                    end else if (timeout && (!irq_mode || (irq && !irq_clear))) begin
                        state <= ST_RESET;
                        sys_reset <= 1'b1;
                        pulse_cnt <= pulse_len - PULSE_ONE;
                    end
                end
                ST_RESET: begin
                    if (pulse_cnt == '0) begin
                        sys_reset <= 1'b0;
                        state <= ST_IDLE;
                    end else begin
                        pulse_cnt <= pulse_cnt - PULSE_ONE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sys_reset <= 1'b0;
                end
            endcase
        end
    end
    //=================================================================
    // interrupt: a new timeout wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else if (timeout && irq_mode) begin
            irq <= 1'b1;
        end else if (irq_clear || state == ST_RESET) begin
            irq <= 1'b0;
        end
    end
    //=================================================================
    // pulse measurement for the checks, kept apart from the counter it judges
    logic [PULSE_CNT_W-1:0] pulse_seen; // cycles the reset request has stood
    logic [PULSE_CNT_W-1:0] pulse_want; // length in force when the pulse began
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_seen <= '0;
        end else if (sys_reset) begin
            pulse_seen <= pulse_seen + PULSE_ONE;
        end else begin
            pulse_seen <= '0;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_want <= '0;
        end else if (!sys_reset) begin
            pulse_want <= pulse_len;
        end
    end
    //=================================================================
    // checks
    reload_on_restart_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_RUN && restart && enable) |=> count == $past(preset))
        else $error("restart did not reload");
    count_down_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_RUN && enable && !restart && count != '0) |=> count == $past(count) - 1)
        else $error("counter did not decrement");
    direct_reset_a: assert property (@(posedge clk) disable iff (rst)
        (timeout && enable && !irq_mode) |=> sys_reset)
        else $error("reset mode missed reset");
    first_irq_a: assert property (@(posedge clk) disable iff (rst)
        (timeout && enable && irq_mode && !irq) |=> irq && !sys_reset)
        else $error("first timeout mishandled");
    second_reset_a: assert property (@(posedge clk) disable iff (rst)
        (timeout && enable && irq_mode && irq && !irq_clear) |=> sys_reset)
        else $error("second timeout missed reset");
    pulse_len_a: assert property (@(posedge clk) disable iff (rst)
        $rose(sys_reset) && pulse_want == 10'h008 |-> sys_reset [*8] ##1 !sys_reset)
        else $error("reset pulse length wrong");
    preset_range_a: assert property (@(posedge clk) disable iff (rst)
        range_sel == 4'h0 |-> preset == 32'h0000_FFFF)
        else $error("range preset wrong");
    clock_count_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_IDLE) |=> count == $past(preset))
        else $error("idle counter not preset");
    //=================================================================
    // checks: counter
    reload_at_zero_a: assert property (@(posedge clk) disable iff (rst)
        timeout |=> count == $past(preset))
        else $error("counter not reloaded after timeout");
    enable_off_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_RUN && !enable) |=> state == ST_IDLE)
        else $error("guard kept running without enable");
    run_start_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_IDLE && enable) |=> (state == ST_RUN && count == $past(preset)))
        else $error("guard did not start from preset");
    preset_top_a: assert property (@(posedge clk) disable iff (rst)
        range_sel == 4'hF |-> preset == 32'h7FFF_FFFF)
        else $error("top range preset wrong");
    //=================================================================
    // checks: response
    state_onehot_a: assert property (@(posedge clk) disable iff (rst)
        $onehot(state))
        else $error("state code not one-hot");
    reset_from_timeout_a: assert property (@(posedge clk) disable iff (rst)
        $rose(sys_reset) |-> $past(timeout))
        else $error("reset request without timeout");
    idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_IDLE |-> !sys_reset)
        else $error("reset request while idle");
    reset_state_a: assert property (@(posedge clk) disable iff (rst)
        sys_reset |-> state == ST_RESET)
        else $error("reset request outside pulse state");
    reset_refuses_run_a: assert property (@(posedge clk) disable iff (rst)
        sys_reset |=> state != ST_RUN)
        else $error("counting resumed inside reset pulse");
    pulse_end_a: assert property (@(posedge clk) disable iff (rst)
        (state == ST_RESET && pulse_cnt == '0) |=> (!sys_reset && state == ST_IDLE))
        else $error("reset pulse did not end");
    //=================================================================
    // checks: interrupt
    irq_from_timeout_a: assert property (@(posedge clk) disable iff (rst)
        $rose(irq) |-> $past(timeout) && $past(irq_mode))
        else $error("interrupt without timeout in interrupt mode");
    irq_holds_a: assert property (@(posedge clk) disable iff (rst)
        (irq && !irq_clear && state != ST_RESET) |=> irq)
        else $error("interrupt dropped without clear");
    clear_drops_irq_a: assert property (@(posedge clk) disable iff (rst)
        (irq_clear && !timeout) |=> !irq)
        else $error("clear did not drop interrupt");
    set_beats_clear_a: assert property (@(posedge clk) disable iff (rst)
        (timeout && irq_mode && irq_clear) |=> irq)
        else $error("timeout lost to clear");
    clear_blocks_reset_a: assert property (@(posedge clk) disable iff (rst)
        (timeout && irq_mode && irq_clear) |=> !sys_reset)
        else $error("reset despite serviced interrupt");
    reset_drops_irq_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_RESET |=> !irq)
        else $error("interrupt kept through reset pulse");
    //=================================================================
    // checks: pulse length
    pulse_width_a: assert property (@(posedge clk) disable iff (rst)
        $fell(sys_reset) |-> pulse_seen == pulse_want)
        else $error("reset pulse length differs from setting");
    pulse_short_a: assert property (@(posedge clk) disable iff (rst)
        pulse_sel == 3'h0 |-> pulse_len == 10'h004)
        else $error("shortest pulse length wrong");
    pulse_long_a: assert property (@(posedge clk) disable iff (rst)
        pulse_sel == 3'h7 |-> pulse_len == 10'h200)
        else $error("longest pulse length wrong");
endmodule
`default_nettype wire

//--- core/timeout_guard_cfg.svh
// constants for the timeout guard
`ifndef TIMEOUT_GUARD_CFG_SVH
`define TIMEOUT_GUARD_CFG_SVH
`define TG_CNT_W      32
`define TG_RANGE_W    4
`define TG_PULSE_W    3
`define TG_RANGE_BASE 16
`define TG_PULSE_BASE 2
`endif

//--- core/timeout_guard_pkg.sv
// types for the timeout guard
package timeout_guard_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_RESET = 3'b100
    } guard_state_t;
endpackage

//--- verif/sw_host_model.sv
// host-side service model: registers bench requests, so each pulse lasts as long as its request
`timescale 1ns/10ps
`default_nettype none
module sw_host_model (
    input  wire logic clk,      // bus clock
    input  wire logic kick,     // restart request
    input  wire logic ack,      // clear request
    output logic      restart,  // reload pulse
    output logic      irq_clear // clear pulse
);
    // registered so pulses launch just after an edge
    always_ff @(posedge clk) begin
        restart   <= kick;
        irq_clear <= ack;
    end
endmodule
`default_nettype wire

//--- verif/timeout_guard_tb.sv
// self-checking bench for the timeout guard
`timescale 1ns/10ps
`default_nettype none
module timeout_guard_tb;
    logic clk = 0, rst = 1, enable = 0, irq_mode = 0, kick = 0, ack = 0;
    logic [3:0] range_sel = 4'h0;
    logic [2:0] pulse_sel = 3'h1;
    logic restart, irq_clear, irq, sys_reset, irq2, sys_reset2;
    logic [31:0] count;
    int failures = 0, n_tests = 0, cyc = 0, n, k;
    always #25 clk = ~clk;
    //==========================================
    // harness
    timeout_guard dut_u (.clk(clk), .rst(rst), .enable(enable), .irq_mode(irq_mode),
        .range_sel(range_sel), .pulse_sel(pulse_sel), .restart(restart),
        .irq_clear(irq_clear), .irq(irq), .sys_reset(sys_reset), .count(count));
    // twin in interrupt mode: same stimulus, so its first timeout lands with dut_u's
    timeout_guard irq_u (.clk(clk), .rst(rst), .enable(enable), .irq_mode(!irq_mode),
        .range_sel(range_sel), .pulse_sel(pulse_sel), .restart(restart),
        .irq_clear(irq_clear), .irq(irq2), .sys_reset(sys_reset2), .count());
    sw_host_model host_u (.clk(clk), .kick(kick), .ack(ack), .restart(restart),
        .irq_clear(irq_clear));
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard: whole run needs about 66k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            failures++;
            end_sim();
        end
    end
    //==========================================
    // scenarios
    task automatic t_ranges();
        for (int r = 0; r < 16; r++) begin
            rst = 1;
            range_sel = 4'(r);
            tick(1);
            rst = 0;
            tick(2);
            chk(count, (32'h1 << (16 + r)) - 32'h1);
            enable = 1;
            tick(4);
            chk(count, (32'h1 << (16 + r)) - 32'h4);
            enable = 0;
        end
        $display("ranges done");
    endtask
    task automatic t_restart_timeout();
        rst = 1;
        range_sel = 4'h0;
        tick(1);
        rst = 0;
        enable = 1;
        tick(20);
        kick = 1;
        tick(1);
        kick = 0;
        tick(1);
        chk(count, 32'h0000FFFF);
        tick(1);
        n = 0;
        while (sys_reset !== 1'b1 && n < 70000) begin
            tick(1);
            n++;
        end
        chk(n, 32'h0000FFFF);
        chk(irq, 1'b0);
        chk(irq2, 1'b1);
        chk(sys_reset2, 1'b0);
        k = 0;
        while (sys_reset === 1'b1 && k < 100) begin
            tick(1);
            k++;
        end
        chk(k, 32'h8);
        ack = 1;
        tick(1);
        ack = 0;
        tick(1);
        chk(irq2, 1'b0);
        $display("restart and timeout done");
    endtask
    initial begin
        tick(16);
        rst = 0;
        t_ranges();
        t_restart_timeout();
        end_sim();
    end
endmodule
`default_nettype wire
